// file: mpu_sfr_ports_flash_ctrl.sv
`timescale 1ns/1ns
module mpu_sfr_ports_flash_ctrl
   import mpu_sfr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_we,
   input wire logic sfr_re,
   output logic [7:0] sfr_rdata,
   output logic sfr_rvalid,
   input wire logic [7:0] port0_pin_in,
   output logic [7:0] port0_pin_out,
   output logic [7:0] port0_pin_oe,
   input wire logic [7:0] port1_pin_in,
   output logic [7:0] port1_pin_out,
   output logic [7:0] port1_pin_oe,
   input wire logic [7:0] port2_pin_in,
   output logic [7:0] port2_pin_out,
   output logic [7:0] port2_pin_oe,
   input wire logic [6:0] external_irq_inputs,
   input wire logic debug_port_enable,
   input wire logic irq_enabled,
   input wire logic preboot_active,
   input wire logic flash_byte_written,
   input wire logic transfer_busy_event,
   input wire logic one_second_event,
   input wire logic pll_fall_event,
   input wire logic eeprom_rx_valid,
   input wire logic [7:0] eeprom_rx_data,
   output logic program_write_enable,
   output logic security_lock,
   output logic page_erase_start,
   output logic mass_erase_start,
   output logic [6:0] erase_page,
   output logic [7:0] eeprom_data_out,
   output logic [7:0] eeprom_control_out,
   output logic eeprom_start,
   output logic watchdog_restart
);
   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic [7:0] port0_level;
   logic [7:0] port1_level;
   logic [7:0] port2_level;
   logic [6:0] irq_level;
   logic [7:0] rd_value;

   logic [7:0] p0_reg, p0_next, p1_reg, p1_next, p2_reg, p2_next;
   logic [7:0] d0_reg, d0_next, d1_reg, d1_next, d2_reg, d2_next;
   logic [6:0] page_reg, page_next;
   logic page_armed_reg, page_armed_next;
   logic page_start_reg, page_start_next;
   logic mass_start_reg, mass_start_next;
   logic pwe_reg, pwe_next, meen_reg, meen_next, secure_reg, secure_next;
   logic [7:0] eeprom_data_reg, eeprom_data_next, eeprom_control_reg, eeprom_control_next;
   logic eestart_reg, eestart_next;
   logic xfer_reg, xfer_next, tick_reg, tick_next, pll_reg, pll_next;
   logic wdog_reg, wdog_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;

   // register write strobe for one address
   function automatic logic wr_hit(input logic we, input logic [7:0] a,
                                   input logic [7:0] target);
      return we && (a == target);
   endfunction : wr_hit

   // reset released through two flops so release is clean
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // pins arrive unsynchronised, so each passes the filter
   pin_sync #(.WIDTH(8)) u_sync_p0 (.sys_clk(sys_clk), .rst_n(rst_n),
      .pin_in(port0_pin_in), .level(port0_level));
   pin_sync #(.WIDTH(8)) u_sync_p1 (.sys_clk(sys_clk), .rst_n(rst_n),
      .pin_in(port1_pin_in), .level(port1_level));
   pin_sync #(.WIDTH(8)) u_sync_p2 (.sys_clk(sys_clk), .rst_n(rst_n),
      .pin_in(port2_pin_in), .level(port2_level));
   pin_sync #(.WIDTH(IRQ_INPUTS)) u_sync_irq (.sys_clk(sys_clk),
      .rst_n(rst_n), .pin_in(external_irq_inputs), .level(irq_level));

   // read mux; absent pins and undefined bits read zero
   always_comb begin
      case (sfr_addr)
         ADDR_PORT0_DATA: rd_value = port0_level & PORT0_PIN_MASK;
         ADDR_PORT1_DATA: rd_value = port1_level & PORT1_PIN_MASK;
         ADDR_PORT2_DATA: rd_value = port2_level & PORT2_PIN_MASK;
         ADDR_PORT0_DIR: rd_value = d0_reg;
         ADDR_PORT1_DIR: rd_value = d1_reg;
         ADDR_PORT2_DIR: rd_value = d2_reg;
         ADDR_EEPROM_DATA: rd_value = eeprom_data_reg;
         ADDR_EEPROM_CTRL: rd_value = eeprom_control_reg;
         ADDR_ERASE_PAGE: rd_value = {1'b0, page_reg};
         ADDR_FLASH_CTRL: rd_value = {preboot_active, secure_reg,
                                      5'h00, pwe_reg};
         ADDR_MULTI_FLAGS: rd_value = {pll_reg, 5'h00, tick_reg,
                                       xfer_reg};
         ADDR_IRQ_LEVELS: rd_value = {1'b0, irq_level};
         default: rd_value = 8'h00;
      endcase
   end

   // next values of every register
   always_comb begin
      p0_next = p0_reg;
      p1_next = p1_reg;
      p2_next = p2_reg;
      d0_next = d0_reg;
      d1_next = d1_reg;
      d2_next = d2_reg;
      page_next = page_reg;
      page_armed_next = page_armed_reg;
      page_start_next = 1'b0;
      mass_start_next = 1'b0;
      pwe_next = pwe_reg;
      meen_next = meen_reg;
      secure_next = secure_reg;
      eeprom_data_next = eeprom_data_reg;
      eeprom_control_next = eeprom_control_reg;
      eestart_next = 1'b0;
      xfer_next = xfer_reg;
      tick_next = tick_reg;
      pll_next = pll_reg;
      wdog_next = 1'b0;
      rvalid_next = sfr_re;
      rdata_next = sfr_re ? rd_value : rdata_reg;
      // eeprom receive first, so a same-cycle software write overrides it
      if (eeprom_rx_valid) eeprom_data_next = eeprom_rx_data;
      // register writes; unknown erase patterns fall through untouched
      if (sfr_we) begin
         case (sfr_addr)
            ADDR_PORT0_DATA: p0_next = sfr_wdata;
            ADDR_PORT1_DATA: p1_next = sfr_wdata;
            ADDR_PORT2_DATA: p2_next = sfr_wdata;
            ADDR_PORT0_DIR: d0_next = sfr_wdata & PORT0_PIN_MASK;
            ADDR_PORT1_DIR: d1_next = sfr_wdata & PORT1_PIN_MASK;
            ADDR_PORT2_DIR: d2_next = sfr_wdata & PORT2_PIN_MASK;
            ADDR_ERASE_CMD: begin
               if (sfr_wdata == ERASE_PAGE_PATTERN && page_armed_reg) begin
                  page_start_next = 1'b1;
                  page_armed_next = 1'b0;
               end else if (sfr_wdata == ERASE_MASS_PATTERN && meen_reg &&
                            debug_port_enable) begin
                  mass_start_next = 1'b1;
                  meen_next = 1'b0;
               end
            end
            ADDR_ERASE_PAGE: begin
               page_next = sfr_wdata[PAGE_WIDTH-1:0];
               page_armed_next = 1'b1;
            end
            ADDR_FLASH_CTRL: begin
               if (!irq_enabled) pwe_next = sfr_wdata[FC_PWE_BIT];
               meen_next = sfr_wdata[FC_MEEN_BIT];
               if (sfr_wdata[FC_SECURE_BIT]) secure_next = 1'b1;
            end
            ADDR_EEPROM_DATA: eeprom_data_next = sfr_wdata;
            ADDR_EEPROM_CTRL: begin
               eeprom_control_next = sfr_wdata;
               eestart_next = 1'b1;
            end
            ADDR_MULTI_FLAGS: begin
               xfer_next = xfer_reg & sfr_wdata[MF_XFER_BIT];
               tick_next = tick_reg & sfr_wdata[MF_TICK_BIT];
               pll_next = pll_reg & sfr_wdata[MF_WDOG_BIT];
               wdog_next = sfr_wdata[MF_WDOG_BIT];
            end
            default: ;
         endcase
      end
      // a byte already went to flash, so the auto-clear wins
      if (flash_byte_written) pwe_next = 1'b0;
      // hardware events set after the clear so a set is never lost
      if (transfer_busy_event) xfer_next = 1'b1;
      if (one_second_event) tick_next = 1'b1;
      if (pll_fall_event) pll_next = 1'b1;
   end

   // register stage
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         p0_reg <= PORT0_DATA_RESET;
         p1_reg <= PORT1_DATA_RESET;
         p2_reg <= PORT2_DATA_RESET;
         d0_reg <= PORT_DIR_RESET;
         d1_reg <= PORT_DIR_RESET;
         d2_reg <= PORT_DIR_RESET;
         page_reg <= ERASE_PAGE_RESET;
         page_armed_reg <= 1'b0;
         page_start_reg <= 1'b0;
         mass_start_reg <= 1'b0;
         pwe_reg <= 1'b0;
         meen_reg <= 1'b0;
         secure_reg <= 1'b0;
         eeprom_data_reg <= EEPROM_RESET;
         eeprom_control_reg <= EEPROM_RESET;
         eestart_reg <= 1'b0;
         xfer_reg <= 1'b0;
         tick_reg <= 1'b0;
         pll_reg <= 1'b0;
         wdog_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         p0_reg <= p0_next;
         p1_reg <= p1_next;
         p2_reg <= p2_next;
         d0_reg <= d0_next;
         d1_reg <= d1_next;
         d2_reg <= d2_next;
         page_reg <= page_next;
         page_armed_reg <= page_armed_next;
         page_start_reg <= page_start_next;
         mass_start_reg <= mass_start_next;
         pwe_reg <= pwe_next;
         meen_reg <= meen_next;
         secure_reg <= secure_next;
         eeprom_data_reg <= eeprom_data_next;
         eeprom_control_reg <= eeprom_control_next;
         eestart_reg <= eestart_next;
         xfer_reg <= xfer_next;
         tick_reg <= tick_next;
         pll_reg <= pll_next;
         wdog_reg <= wdog_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // outputs straight from flops
   assign port0_pin_out = p0_reg;
   assign port1_pin_out = p1_reg;
   assign port2_pin_out = p2_reg;
   assign port0_pin_oe = d0_reg;
   assign port1_pin_oe = d1_reg;
   assign port2_pin_oe = d2_reg;
   assign erase_page = page_reg;
   assign page_erase_start = page_start_reg;
   assign mass_erase_start = mass_start_reg;
   assign program_write_enable = pwe_reg;
   assign security_lock = secure_reg;
   assign eeprom_data_out = eeprom_data_reg;
   assign eeprom_control_out = eeprom_control_reg;
   assign eeprom_start = eestart_reg;
   assign watchdog_restart = wdog_reg;
   assign sfr_rdata = rdata_reg;
   assign sfr_rvalid = rvalid_reg;

   // checks
   property p_port1_drive;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_hit(sfr_we, sfr_addr, ADDR_PORT1_DATA) |=>
         port1_pin_out == $past(sfr_wdata);
   endproperty
   a_port1_drive: assert property (p_port1_drive)
      else $error("port1 latch not loaded");

   property p_port0_dir;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_hit(sfr_we, sfr_addr, ADDR_PORT0_DIR) |=>
         port0_pin_oe == ($past(sfr_wdata) & 8'hF0);
   endproperty
   a_port0_dir: assert property (p_port0_dir)
      else $error("port0 direction wrong");

   property p_port2_read;
      @(posedge sys_clk) disable iff (!rst_n)
      (sfr_re && sfr_addr == 8'hA0) |=>
         sfr_rvalid && sfr_rdata == ($past(port2_level) & 8'h3B);
   endproperty
   a_port2_read: assert property (p_port2_read)
      else $error("port2 read not pin level");

   property p_page_erase;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(page_erase_start) |-> $past(sfr_we) &&
         $past(sfr_addr) == 8'h94 && $past(sfr_wdata) == 8'h55;
   endproperty
   a_page_erase: assert property (p_page_erase)
      else $error("page erase without command");

   property p_mass_erase;
      @(posedge sys_clk) disable iff (!rst_n)
      mass_erase_start |-> $past(meen_reg) && $past(debug_port_enable)
         && $past(sfr_wdata) == 8'hAA;
   endproperty
   a_mass_erase: assert property (p_mass_erase)
      else $error("mass erase without enable");

   property p_bad_pattern;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_hit(sfr_we, sfr_addr, ADDR_ERASE_CMD) && sfr_wdata != 8'h55 &&
       sfr_wdata != 8'hAA) |=> !page_erase_start && !mass_erase_start;
   endproperty
   a_bad_pattern: assert property (p_bad_pattern)
      else $error("unknown pattern started erase");

   property p_pwe_lock;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(program_write_enable) |-> !$past(irq_enabled);
   endproperty
   a_pwe_lock: assert property (p_pwe_lock)
      else $error("write enable set with irq on");

   property p_secure_sticky;
      @(posedge sys_clk) disable iff (!rst_n)
      security_lock |=> security_lock;
   endproperty
   a_secure_sticky: assert property (p_secure_sticky)
      else $error("security bit cleared");

   property p_xfer_set;
      @(posedge sys_clk) disable iff (!rst_n)
      transfer_busy_event |=> xfer_reg;
   endproperty
   a_xfer_set: assert property (p_xfer_set)
      else $error("transfer flag not set");

   property p_wdog;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_hit(sfr_we, sfr_addr, ADDR_MULTI_FLAGS) && sfr_wdata[7]) |=>
         watchdog_restart ##1 !watchdog_restart || sfr_we;
   endproperty
   a_wdog: assert property (p_wdog)
      else $error("watchdog restart missing");

   property p_fc_read;
      @(posedge sys_clk) disable iff (!rst_n)
      (sfr_re && sfr_addr == 8'hB2) |=> sfr_rdata[5:1] == 5'h00 &&
         sfr_rdata[7] == $past(preboot_active);
   endproperty
   a_fc_read: assert property (p_fc_read)
      else $error("flash control reserved bits set");
endmodule : mpu_sfr_ports_flash_ctrl

// file: mpu_sfr_pkg.sv
package mpu_sfr_pkg;
   // special register space addresses
   localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
   localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
   localparam logic [7:0] ADDR_PORT1_DIR = 8'h91;
   localparam logic [7:0] ADDR_ERASE_CMD = 8'h94;
   localparam logic [7:0] ADDR_EEPROM_DATA = 8'h9E;
   localparam logic [7:0] ADDR_EEPROM_CTRL = 8'h9F;
   localparam logic [7:0] ADDR_PORT2_DATA = 8'hA0;
   localparam logic [7:0] ADDR_PORT2_DIR = 8'hA1;
   localparam logic [7:0] ADDR_PORT0_DIR = 8'hA2;
   localparam logic [7:0] ADDR_FLASH_CTRL = 8'hB2;
   localparam logic [7:0] ADDR_ERASE_PAGE = 8'hB7;
   localparam logic [7:0] ADDR_MULTI_FLAGS = 8'hE8;
   localparam logic [7:0] ADDR_IRQ_LEVELS = 8'hF8;

   // erase command patterns
   localparam logic [7:0] ERASE_PAGE_PATTERN = 8'h55;
   localparam logic [7:0] ERASE_MASS_PATTERN = 8'hAA;

   // bits present as pins on each port (bit i of port n is pin 8n+i)
   localparam logic [7:0] PORT0_PIN_MASK = 8'hF0;
   localparam logic [7:0] PORT1_PIN_MASK = 8'hCF;
   localparam logic [7:0] PORT2_PIN_MASK = 8'h3B;

   // reset values
   localparam logic [7:0] PORT0_DATA_RESET = 8'hFF;
   localparam logic [7:0] PORT1_DATA_RESET = 8'hFF;
   localparam logic [7:0] PORT2_DATA_RESET = 8'h00;
   localparam logic [7:0] PORT_DIR_RESET = 8'h00;
   localparam logic [6:0] ERASE_PAGE_RESET = 7'h00;
   localparam logic [7:0] EEPROM_RESET = 8'h00;

   // flash control field positions
   localparam int FC_PWE_BIT = 0;
   localparam int FC_MEEN_BIT = 1;
   localparam int FC_SECURE_BIT = 6;
   localparam int FC_PREBOOT_BIT = 7;

   // multi-purpose flag field positions
   localparam int MF_XFER_BIT = 0;
   localparam int MF_TICK_BIT = 1;
   localparam int MF_WDOG_BIT = 7;

   localparam int PAGE_WIDTH = 7;
   localparam int IRQ_INPUTS = 7;
endpackage : mpu_sfr_pkg

// file: pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] level_reg;
   logic [WIDTH-1:0] level_next;

   // a bit only moves once two late stages agree, filtering glitches
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always_comb begin
            level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i]
                                                     : level_reg[i];
         end
      end
   endgenerate

   // s1 feeds only s2
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         level_reg <= '0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= level_next;
      end
   end

   assign level = level_reg;
endmodule : pin_sync

// file: sfr_core_model.sv
`timescale 1ns/1ns
// core side of the register bus, one access at a time
module sfr_core_model (
   input wire logic sys_clk,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_rvalid,
   output logic [7:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   output logic sfr_we,
   output logic sfr_re
);
   // strobes idle low from time zero
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_we = 1'b0;
      sfr_re = 1'b0;
   end

   // whole-byte write, held up to the sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_we <= 1'b1;
      @(posedge sys_clk);
      sfr_we <= 1'b0;
      sfr_wdata <= ~d; // stale data must not look valid
   endtask : wr

   // read strobe one cycle, answer sampled once it has settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_re <= 1'b1;
      @(posedge sys_clk);
      sfr_re <= 1'b0;
      #1;
      d = sfr_rdata;
      v = sfr_rvalid;
   endtask : rd
endmodule : sfr_core_model

// file: mpu_sfr_ports_flash_ctrl_tb.sv
`timescale 1ns/1ns
module mpu_sfr_ports_flash_ctrl_tb;
   import mpu_sfr_pkg::*;
   localparam logic [7:0] DADR [3] = '{8'h80, 8'h90, 8'hA0};
   localparam logic [7:0] RADR [3] = '{8'hA2, 8'h91, 8'hA1};
   localparam logic [7:0] MSK [3] = '{8'hF0, 8'hCF, 8'h3B};
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic sfr_we, sfr_re, sfr_rvalid;
   logic [7:0] ext [3];
   logic [7:0] pin_in [3];
   logic [7:0] pin_out [3];
   logic [7:0] pin_oe [3];
   logic [6:0] external_irq_inputs;
   logic debug_port_enable, irq_enabled, preboot_active;
   logic flash_byte_written, eeprom_rx_valid;
   logic transfer_busy_event, one_second_event, pll_fall_event;
   logic [7:0] eeprom_rx_data, eeprom_data_out, eeprom_control_out;
   logic program_write_enable, security_lock, eeprom_start;
   logic page_erase_start, mass_erase_start, watchdog_restart;
   logic [6:0] erase_page;
   logic [31:0] seed = 32'h5A0C;
   logic [7:0] d, di, e;
   int pe_n = 0;
   int me_n = 0;
   int ee_n = 0;
   int wd_n = 0;
   int error_cnt = 0;
   int checks = 0;

   always #10 sys_clk = ~sys_clk;

   // pin level: our driver where enabled, the outside world elsewhere
   always_comb begin
      for (int n = 0; n < 3; n++) begin
         pin_in[n] = (pin_oe[n] & pin_out[n]) | (~pin_oe[n] & ext[n]);
      end
   end

   // pulse counters, so extra, lost or stretched pulses cannot hide
   always @(posedge sys_clk) begin
      pe_n <= pe_n + int'(page_erase_start);
      me_n <= me_n + int'(mass_erase_start);
      ee_n <= ee_n + int'(eeprom_start);
      wd_n <= wd_n + int'(watchdog_restart);
   end

   mpu_sfr_ports_flash_ctrl i_mpu_sfr_ports_flash_ctrl (
      .sys_clk(sys_clk), .resetn(resetn), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re),
      .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
      .port0_pin_in(pin_in[0]), .port0_pin_out(pin_out[0]),
      .port0_pin_oe(pin_oe[0]), .port1_pin_in(pin_in[1]),
      .port1_pin_out(pin_out[1]), .port1_pin_oe(pin_oe[1]),
      .port2_pin_in(pin_in[2]), .port2_pin_out(pin_out[2]),
      .port2_pin_oe(pin_oe[2]), .external_irq_inputs(external_irq_inputs),
      .debug_port_enable(debug_port_enable), .irq_enabled(irq_enabled),
      .preboot_active(preboot_active),
      .flash_byte_written(flash_byte_written),
      .transfer_busy_event(transfer_busy_event),
      .one_second_event(one_second_event), .pll_fall_event(pll_fall_event),
      .eeprom_rx_valid(eeprom_rx_valid), .eeprom_rx_data(eeprom_rx_data),
      .program_write_enable(program_write_enable),
      .security_lock(security_lock), .page_erase_start(page_erase_start),
      .mass_erase_start(mass_erase_start), .erase_page(erase_page),
      .eeprom_data_out(eeprom_data_out),
      .eeprom_control_out(eeprom_control_out),
      .eeprom_start(eeprom_start), .watchdog_restart(watchdog_restart)
   );

   sfr_core_model i_sfr_core_model (
      .sys_clk(sys_clk), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
      .sfr_re(sfr_re)
   );

   // xorshift, repeatable from the fixed seed
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   // readback sees the pin, so outputs show the latch
   function automatic logic [7:0] pin_read(input logic [7:0] dv,
      input logic [7:0] dir, input logic [7:0] ev, input logic [7:0] m);
      return ((dir & dv) | (~dir & ev)) & m;
   endfunction : pin_read

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_sfr_core_model.wr(a, v);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] got;
      logic v;
      i_sfr_core_model.rd(a, got, v);
      chk(got, exp);
      chk({7'h00, v}, 8'h01);
   endtask : rdchk

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic results();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   // hang guard, far beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      $display("Error %0t: watchdog expired", $time);
      results();
   end

   initial begin
      for (int n = 0; n < 3; n++) ext[n] = 8'h00;
      {external_irq_inputs, eeprom_rx_data} = 15'h0000;
      {debug_port_enable, irq_enabled, preboot_active} = 3'h0;
      {flash_byte_written, eeprom_rx_valid} = 2'h0;
      {transfer_busy_event, one_second_event, pll_fall_event} = 3'h0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      settle(4);
      chk(pin_out[0], PORT0_DATA_RESET);
      chk(pin_out[1], PORT1_DATA_RESET);
      chk(pin_out[2], PORT2_DATA_RESET);
      for (int n = 0; n < 3; n++) chk(pin_oe[n], 8'h00);
      rdchk(ADDR_ERASE_PAGE, 8'h00);
      rdchk(ADDR_ERASE_CMD, 8'h00);
      rdchk(8'h81, 8'h00);
      // ports: all-out, all-in, then random directions
      for (int r = 0; r < 4; r++) begin
         for (int n = 0; n < 3; n++) begin
            d = rnd();
            di = (r == 0) ? 8'hFF : (r == 1) ? 8'h00 : rnd();
            e = rnd();
            @(posedge sys_clk);
            ext[n] <= e;
            wr(DADR[n], d);
            wr(RADR[n], di);
            settle(6);
            chk(pin_out[n] & MSK[n], d & MSK[n]);
            chk(pin_oe[n], di & MSK[n]);
            rdchk(DADR[n], pin_read(d, di, e, MSK[n]));
         end
      end
      // page erase, then a second one without a new page
      wr(ADDR_ERASE_PAGE, 8'h7F);
      wr(ADDR_ERASE_CMD, ERASE_PAGE_PATTERN);
      wr(ADDR_ERASE_CMD, ERASE_PAGE_PATTERN);
      settle(3);
      chk(8'(pe_n), 8'h01);
      chk({1'b0, erase_page}, 8'h7F);
      @(posedge sys_clk);
      debug_port_enable <= 1'b1;
      wr(ADDR_ERASE_PAGE, 8'h05);
      wr(ADDR_FLASH_CTRL, 8'h02);
      for (int k = 0; k < 6; k++) begin
         // bit 7 and bit 0 forced so neither defined pattern can appear
         e = (k == 5) ? rnd() | 8'h81 : 8'h54 + 8'(k * 2);
         wr(ADDR_ERASE_CMD, e);
      end
      settle(3);
      chk(8'(pe_n + me_n), 8'h01);
      wr(ADDR_ERASE_CMD, ERASE_PAGE_PATTERN);
      wr(ADDR_ERASE_CMD, ERASE_MASS_PATTERN);
      wr(ADDR_ERASE_CMD, ERASE_MASS_PATTERN);
      settle(3);
      chk(8'(pe_n), 8'h02);
      chk({1'b0, erase_page}, 8'h05);
      chk(8'(me_n), 8'h01);
      @(posedge sys_clk);
      debug_port_enable <= 1'b0;
      wr(ADDR_FLASH_CTRL, 8'h02);
      wr(ADDR_ERASE_CMD, ERASE_MASS_PATTERN);
      settle(3);
      chk(8'(me_n), 8'h01);
      // serial eeprom: data then control starts the transfer
      d = rnd();
      e = rnd();
      wr(ADDR_EEPROM_DATA, d);
      wr(ADDR_EEPROM_CTRL, e);
      settle(3);
      chk(8'(ee_n), 8'h01);
      chk(eeprom_data_out, d);
      chk(eeprom_control_out, e);
      @(posedge sys_clk);
      eeprom_rx_valid <= 1'b1;
      eeprom_rx_data <= ~d;
      @(posedge sys_clk);
      eeprom_rx_valid <= 1'b0;
      rdchk(ADDR_EEPROM_DATA, ~d);
      // program write enable: self clear, locked while irq on
      wr(ADDR_FLASH_CTRL, 8'h01);
      settle(2);
      chk({7'h00, program_write_enable}, 8'h01);
      @(posedge sys_clk);
      flash_byte_written <= 1'b1;
      @(posedge sys_clk);
      flash_byte_written <= 1'b0;
      irq_enabled <= 1'b1;
      settle(2);
      chk({7'h00, program_write_enable}, 8'h00);
      wr(ADDR_FLASH_CTRL, 8'h01);
      settle(2);
      chk({7'h00, program_write_enable}, 8'h00);
      @(posedge sys_clk);
      irq_enabled <= 1'b0;
      // security sticks, undefined bits and enable read zero
      wr(ADDR_FLASH_CTRL, 8'h7E);
      wr(ADDR_FLASH_CTRL, 8'h00);
      settle(2);
      chk({7'h00, security_lock}, 8'h01);
      rdchk(ADDR_FLASH_CTRL, 8'h40);
      @(posedge sys_clk);
      preboot_active <= 1'b1;
      rdchk(ADDR_FLASH_CTRL, 8'hC0);
      // flags set by events, cleared by zero bits of a byte write
      @(posedge sys_clk);
      {transfer_busy_event, one_second_event, pll_fall_event} <= 3'h7;
      @(posedge sys_clk);
      {transfer_busy_event, one_second_event, pll_fall_event} <= 3'h0;
      rdchk(ADDR_MULTI_FLAGS, 8'h83);
      wr(ADDR_MULTI_FLAGS, 8'h7E);
      rdchk(ADDR_MULTI_FLAGS, 8'h02);
      chk(8'(wd_n), 8'h00);
      wr(ADDR_MULTI_FLAGS, 8'h80);
      settle(3);
      chk(8'(wd_n), 8'h01);
      rdchk(ADDR_MULTI_FLAGS, 8'h00);
      // live interrupt input levels
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 8'h7F : rnd();
         @(posedge sys_clk);
         external_irq_inputs <= d[6:0];
         settle(6);
         rdchk(ADDR_IRQ_LEVELS, {1'b0, d[6:0]});
      end
      results();
   end
endmodule : mpu_sfr_ports_flash_ctrl_tb
